// File: shared/fsw_cfg.svh
// constants of the flash status and write-protect register logic
// assumes a 50 MHz system clock that oversamples the serial pins
`ifndef FSW_CFG_SVH
`define FSW_CFG_SVH

// ----------------------------------------------------------------
// command opcodes
// ----------------------------------------------------------------
`define FSW_OP_WREN      8'h06
`define FSW_OP_WRDI      8'h04
`define FSW_OP_VWREN     8'h50
`define FSW_OP_RDSR1     8'h05
`define FSW_OP_RDSR2     8'h35
`define FSW_OP_RDSR3     8'h15
`define FSW_OP_WRSR1     8'h01
`define FSW_OP_WRSR2     8'h31
`define FSW_OP_WRSR3     8'h11
`define FSW_OP_PP        8'h02
`define FSW_OP_SE        8'h20
`define FSW_OP_BE        8'hD8
`define FSW_OP_CE1       8'hC7
`define FSW_OP_CE2       8'h60
`define FSW_OP_RSTEN     8'h66
`define FSW_OP_RST       8'h99

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define FSW_SR1_BUSY     0
`define FSW_SR1_WEL      1
`define FSW_SR1_BP_LO    2
`define FSW_SR1_TB       5
`define FSW_SR1_SEC      6
`define FSW_SR1_STATUS_PROTECT_LOWER     7
`define FSW_SR2_STATUS_PROTECT_UPPER     0
`define FSW_SR2_QE       1
`define FSW_SR2_LB_LO    3
`define FSW_SR2_CMP      6
`define FSW_SR2_SUS      7
`define FSW_SR3_WPS      2
`define FSW_SR3_HFM      4
`define FSW_SR3_DRV_LO   5
`define FSW_SR3_PIN_ROLE_SELECT     7

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define FSW_DRV_RST      2'h3
`define FSW_HFM_RST      1'h1
`define FSW_WPS_RST      1'h0
`define FSW_BP_RST       3'h0
`define FSW_BIT_RST      1'h0

// ----------------------------------------------------------------
// array geometry and timing
// ----------------------------------------------------------------
`define FSW_ARRAY_BYTES  25'h1000000
`define FSW_BLOCK_SHIFT  16
`define FSW_SECTOR_SHIFT 12
`define FSW_CLK_MHZ      50
`define FSW_T_W_US       100
`define FSW_T_PP_US      400
`define FSW_T_SE_US      4000

`endif

// File: shared/fsw_pkg.sv
// types of the flash status and write-protect register logic
// assumes fsw_cfg.svh holds all numeric constants
package fsw_pkg;

  // protection and configuration bits held in both copies
  typedef struct packed {
    logic       status_protect_upper;
    logic       status_protect_lower;
    logic       cmp;
    logic       qe;
    logic       sec;
    logic       tb;
    logic [2:0] bp;
    logic       pin_role_select;
    logic [1:0] drv;
    logic       high_frequency_select;
    logic       protect_scheme_select;
  } fsw_cfg_t;

  typedef enum logic [1:0] {
    FSW_IDLE  = 2'b00,
    FSW_WRSR  = 2'b01,
    FSW_PROG  = 2'b10,
    FSW_ERASE = 2'b11
  } fsw_op_t;

  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic mosi;
    logic wp_n;
    logic hr_n;
  } fsw_pins_t;

  typedef struct packed {
    logic        sclk_q;
    logic        cs_q;
    logic [7:0]  sh_in;
    logic [2:0]  bitcnt;
    logic [2:0]  nbytes;
    logic [7:0]  cmd;
    logic [7:0]  d1;
    logic [7:0]  d2;
    logic [7:0]  d3;
    logic [7:0]  sh_out;
    logic        miso;
    logic        miso_oe;
    logic        write_enable_latch;
    logic        volwe;
    logic        rst_armed;
    fsw_op_t     op;
    logic [23:0] busy_cnt;
    fsw_cfg_t    nv;
    fsw_cfg_t    vol;
    logic [2:0]  lb;
    logic        reject;
    logic        hold_act;
  } fsw_state_t;

endpackage

// File: sim/flash_status_write_protect_tb.sv
// self-checking bench for the status and write-protect registers
// assumes fsw_host_model as serial host and the bound port checker
module flash_status_write_protect_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk_sys = 1'b0;
  logic       srst = 1'b1;
  logic       wp_n = 1'b1;
  logic       hold_n = 1'b1;
  logic       cs_n, sclk, mosi, miso, miso_oe, high_frequency_select, quad, hold_act, busy, reject, c;
  logic [1:0] drive;
  logic [7:0] rx, d;
  logic [23:0] a;
  int         fail_count = 0;
  int         total_checks = 0;
  int         rej = 0;
  int         n;
  always #10 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (reject === 1'b1) rej++;
  fsw_top #(.WRSR_CYCLES(300), .PROG_CYCLES(300), .ERASE_CYCLES(400)) uut (
    .CLK_SYS(clk_sys), .SRST(srst), .CS_N(cs_n), .SCLK(sclk), .MOSI(mosi), .WP_N(wp_n),
    .HOLD_RESET_N(hold_n), .MISO(miso), .MISO_OE(miso_oe), .DRIVE_STRENGTH(drive),
    .HIGH_FREQ_MODE(high_frequency_select), .QUAD_MODE(quad), .HOLD_ACTIVE(hold_act), .BUSY(busy),
    .ARRAY_REJECT(reject));
  fsw_host_model host (.clk(clk_sys), .miso(miso), .cs_n(cs_n), .sclk(sclk), .mosi(mosi));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(logic [7:0] seen, logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t ns: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rd(logic [7:0] op, logic [7:0] exp);
    logic [7:0] v;
    host.frame(2, {op, 24'h0}, v);
    chk(v, exp);
  endtask
  task automatic cmd(logic [7:0] op);
    logic [7:0] v;
    host.frame(1, {op, 24'h0}, v);
  endtask
  task automatic wr(logic [7:0] en, logic [7:0] op, logic [7:0] dat);
    logic [7:0] v;
    cmd(en);
    host.frame(2, {op, dat, 16'h0}, v);
    host.poll();
    chk({7'h0, busy}, 8'h00);
  endtask
  // sector erase at adr, then compare reject pulses against exp
  task automatic erase(logic [23:0] adr, logic exp);
    logic [7:0] v;
    n = rej;
    cmd(8'h06);
    host.frame(4, {8'h20, adr}, v);
    host.poll();
    chk({7'h0, busy}, 8'h00);
    chk(8'(rej - n), {7'h0, exp});
  endtask
  function automatic logic prot(logic [7:0] sr1, logic cm, logic [23:0] adr);
    int span;
    logic hit;
    span = ((sr1[6] ? 4096 : 65536) << sr1[4:2]) >> 1;
    hit = sr1[5] ? int'(adr) < span : int'(adr) >= 16777216 - span;
    if (sr1[4:2] == 3'h7 && !sr1[6])
      hit = 1'b1;
    return (sr1[4:2] != 3'h0 && hit) ^ cm;
  endfunction
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial
  begin
    #2_000_000;
    fail_count++;
    print_verdict();
  end
  initial
  begin
    void'($urandom(69677));
    repeat (10) @(negedge clk_sys);
    srst = 1'b0;
    repeat (3) @(negedge clk_sys);
    rd(8'h05, 8'h00);
    rd(8'h35, 8'h00);
    rd(8'h15, 8'h70);
    chk({4'h0, quad, drive, high_frequency_select}, 8'h07);
    cmd(8'h06);
    rd(8'h05, 8'h02);
    cmd(8'h04);
    rd(8'h05, 8'h00);
    cmd(8'h06);
    host.frame(2, 32'h1170_0000, rx);
    repeat (6) @(negedge clk_sys);
    chk({7'h0, busy}, 8'h01);
    cmd(8'h06);
    rd(8'h05, 8'h01);
    host.poll();
    rd(8'h05, 8'h00);
    $display("test reset and latch done");
    for (int i = 0; i < 4; i++)
    begin
      d = 8'($urandom);
      wr(8'h06, 8'h11, d);
      rd(8'h15, d & 8'hF4);
      chk({5'h0, drive, high_frequency_select}, {5'h0, d[6:4]});
    end
    wr(8'h06, 8'h11, 8'h74);
    erase(24'h0, 1'b1);
    wr(8'h06, 8'h11, 8'h70);
    $display("test config done");
    for (int i = 0; i < 8; i++)
    begin
      d = {1'b0, 5'($urandom), 2'b00};
      c = 1'($urandom);
      a = {12'($urandom), 12'h000};
      wr(8'h06, 8'h01, d);
      wr(8'h06, 8'h31, {1'b0, c, 6'h0});
      erase(a, prot(d, c, a));
      rd(8'h05, d);
    end
    wr(8'h06, 8'h01, 8'h00);
    wr(8'h06, 8'h31, 8'h00);
    $display("test array protect done");
    wp_n = 1'b0;
    wr(8'h06, 8'h01, 8'h80);
    rd(8'h05, 8'h80);
    wr(8'h06, 8'h01, 8'h84);
    rd(8'h05, 8'h80);
    wp_n = 1'b1;
    wr(8'h06, 8'h01, 8'h00);
    rd(8'h05, 8'h00);
    wr(8'h06, 8'h31, 8'h01);
    wr(8'h06, 8'h01, 8'h04);
    rd(8'h05, 8'h00);
    cmd(8'h66);
    cmd(8'h99);
    rd(8'h35, 8'h00);
    wr(8'h06, 8'h01, 8'h80);
    wr(8'h06, 8'h31, 8'h01);
    wr(8'h06, 8'h01, 8'h04);
    cmd(8'h66);
    cmd(8'h99);
    rd(8'h05, 8'h80);
    rd(8'h35, 8'h01);
    srst = 1'b1;
    repeat (3) @(negedge clk_sys);
    srst = 1'b0;
    repeat (3) @(negedge clk_sys);
    rd(8'h35, 8'h00);
    $display("test status protect done");
    wr(8'h50, 8'h11, 8'h50);
    rd(8'h15, 8'h50);
    chk({6'h0, drive}, 8'h02);
    cmd(8'h66);
    cmd(8'h99);
    rd(8'h15, 8'h70);
    hold_n = 1'b0;
    repeat (8) @(negedge clk_sys);
    chk({7'h0, hold_act}, 8'h01);
    hold_n = 1'b1;
    wr(8'h06, 8'h31, 8'h02);
    hold_n = 1'b0;
    repeat (8) @(negedge clk_sys);
    chk({6'h0, quad, hold_act}, 8'h02);
    hold_n = 1'b1;
    wr(8'h06, 8'h31, 8'h00);
    // pin in reset role: a low level reloads the copies and clears the latch
    wr(8'h50, 8'h11, 8'hF0);
    rd(8'h15, 8'hF0);
    cmd(8'h06);
    hold_n = 1'b0;
    repeat (8) @(negedge clk_sys);
    hold_n = 1'b1;
    repeat (8) @(negedge clk_sys);
    rd(8'h05, 8'h00);
    rd(8'h15, 8'h70);
    $display("test volatile and pin done");
    print_verdict();
  end
endmodule

// File: sim/fsw_host_model.sv
// serial host controller issuing status and array commands, mode 0
// assumes the bench calls its tasks; pins change on falling clock edges
module fsw_host_model (
  input  wire logic clk,
  input  wire logic miso,
  output logic      cs_n,
  output logic      sclk,
  output logic      mosi
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    cs_n = 1'b1;
    sclk = 1'b0;
    mosi = 1'b0;
  end
  // n whole bytes msb first from the top of tx; last byte read back
  task automatic frame(input int n, input logic [31:0] tx, output logic [7:0] rx);
    cs_n = 1'b0;
    for (int i = 0; i < 8 * n; i++)
    begin
      mosi = tx[31];
      tx = tx << 1;
      repeat (4) @(negedge clk);
      sclk = 1'b1;
      repeat (4) @(negedge clk);
      rx = {rx[6:0], miso};
      sclk = 1'b0;
    end
    repeat (4) @(negedge clk);
    cs_n = 1'b1;
    mosi = ~mosi;
    repeat (12) @(negedge clk);
  endtask
  // at most 40 status reads until the busy flag clears
  task automatic poll();
    logic [7:0] st;
    st = 8'h01;
    for (int t = 0; t < 40 && st[0]; t++)
      frame(2, 32'h0500_0000, st);
  endtask
endmodule

// File: sim/fsw_top_assertions.sv
// port checks for the status and write-protect register block
// assumes bind onto fsw_top, one clock domain, synchronous reset
module fsw_top_assertions #(
  parameter int WRSR_CYCLES  = 5000,
  parameter int PROG_CYCLES  = 20000,
  parameter int ERASE_CYCLES = 200000
) (
  input wire logic       CLK_SYS,
  input wire logic       SRST,
  input wire logic       CS_N,
  input wire logic       HOLD_RESET_N,
  input wire logic       MISO_OE,
  input wire logic [1:0] DRIVE_STRENGTH,
  input wire logic       HIGH_FREQ_MODE,
  input wire logic       QUAD_MODE,
  input wire logic       HOLD_ACTIVE,
  input wire logic       BUSY,
  input wire logic       ARRAY_REJECT
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (SRST);
  // ----------------------------------------------------------------
  // busy length counter
  // ----------------------------------------------------------------
  logic [31:0] busy_len_r;
  always_ff @(posedge CLK_SYS)
  begin
    if (SRST || !BUSY)
      busy_len_r <= '0;
    else
      busy_len_r <= busy_len_r + 32'h1;
  end
  chk_reset_values: assert property ($fell(SRST) |-> DRIVE_STRENGTH == 2'h3
    && HIGH_FREQ_MODE && !QUAD_MODE && !BUSY) else $error("bad values after reset");
  chk_busy_after_cmd: assert property ($rose(BUSY) |-> CS_N && $past(CS_N, 2))
    else $error("busy rose inside a frame");
  chk_busy_bounded: assert property (BUSY |-> busy_len_r <= ERASE_CYCLES + 2)
    else $error("busy held too long");
  chk_busy_length: assert property ($fell(BUSY) |-> busy_len_r inside
    {[WRSR_CYCLES-2:WRSR_CYCLES+2], [PROG_CYCLES-2:PROG_CYCLES+2],
     [ERASE_CYCLES-2:ERASE_CYCLES+2]}) else $error("busy length wrong");
  chk_reject_pulse: assert property (ARRAY_REJECT |=> (!ARRAY_REJECT && !BUSY) [*4])
    else $error("reject not a lone pulse or busy followed");
  chk_reject_idle: assert property (ARRAY_REJECT |-> !BUSY && CS_N)
    else $error("reject while busy or selected");
  chk_read_in_frame: assert property ($rose(MISO_OE) |-> !CS_N && !$past(CS_N, 3))
    else $error("output enabled outside a read");
  chk_config_steady: assert property ($changed(DRIVE_STRENGTH) || $changed(HIGH_FREQ_MODE)
    |-> CS_N && $past(CS_N, 2)) else $error("config changed inside a frame");
  chk_hold_no_quad: assert property (HOLD_ACTIVE |-> !QUAD_MODE
    && !$past(HOLD_RESET_N, 3)) else $error("pause without low pin or in quad");
  cover property ($rose(BUSY));
  cover property (ARRAY_REJECT);
  cover property ($rose(MISO_OE) && BUSY);
endmodule

bind fsw_top fsw_top_assertions #(.WRSR_CYCLES(WRSR_CYCLES), .PROG_CYCLES(PROG_CYCLES),
  .ERASE_CYCLES(ERASE_CYCLES)) chk (.CLK_SYS, .SRST, .CS_N, .HOLD_RESET_N, .MISO_OE,
  .DRIVE_STRENGTH, .HIGH_FREQ_MODE, .QUAD_MODE, .HOLD_ACTIVE, .BUSY, .ARRAY_REJECT);

// File: verilog/fsw_sync.sv
// two-stage synchroniser for a group of pin inputs
// assumes each bit is a level from outside the clock domain
module fsw_sync #(
  parameter int W = 5
) (
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_r;

  // first stage feeds only the second stage
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      meta_r <= '1;
      q      <= '1;
    end
    else
    begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule

// File: verilog/fsw_top.sv
// status, configuration and write-protect registers of a serial flash
// assumes a mode-0 serial host, oversampled by CLK_SYS; SRST is power-up
`include "fsw_cfg.svh"

module fsw_top #(
  parameter int WRSR_CYCLES  = `FSW_T_W_US * `FSW_CLK_MHZ,
  parameter int PROG_CYCLES  = `FSW_T_PP_US * `FSW_CLK_MHZ,
  parameter int ERASE_CYCLES = `FSW_T_SE_US * `FSW_CLK_MHZ
) (
  input  wire logic       CLK_SYS,
  input  wire logic       SRST,
  input  wire logic       CS_N,
  input  wire logic       SCLK,
  input  wire logic       MOSI,
  input  wire logic       WP_N,
  input  wire logic       HOLD_RESET_N,
  output logic            MISO,
  output logic            MISO_OE,
  output logic [1:0]      DRIVE_STRENGTH,
  output logic            HIGH_FREQ_MODE,
  output logic            QUAD_MODE,
  output logic            HOLD_ACTIVE,
  output logic            BUSY,
  output logic            ARRAY_REJECT
);
  import fsw_pkg::*;

  fsw_pins_t  pin_raw;
  fsw_pins_t  pin;
  fsw_state_t st_r;
  fsw_state_t st_nxt;

  assign pin_raw = '{cs_n: CS_N, sclk: SCLK, mosi: MOSI, wp_n: WP_N, hr_n: HOLD_RESET_N};

  fsw_sync #(
    .W ($bits(fsw_pins_t))
  ) u_sync (
    .clk  (CLK_SYS),
    .srst (SRST),
    .d    (pin_raw),
    .q    (pin)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic fsw_cfg_t cfg_reset();
    fsw_cfg_t c;
    c      = '0;
    c.bp   = `FSW_BP_RST;
    c.drv  = `FSW_DRV_RST;
    c.high_frequency_select  = `FSW_HFM_RST;
    c.protect_scheme_select  = `FSW_WPS_RST;
    return c;
  endfunction

  // lock-down clears on reset; other settings persist
  function automatic fsw_cfg_t cfg_unlock(fsw_cfg_t c);
    fsw_cfg_t r;
    r = c;
    if (c.status_protect_upper && !c.status_protect_lower)
    begin
      r.status_protect_upper = 1'b0;
    end
    return r;
  endfunction

  // store one status byte; read-only and reserved bits are skipped
  function automatic fsw_cfg_t cfg_write(fsw_cfg_t c, logic [1:0] idx, logic [7:0] d);
    fsw_cfg_t r;
    r = c;
    case (idx)
      2'h1:
      begin
        r.status_protect_lower = d[`FSW_SR1_STATUS_PROTECT_LOWER];
        r.sec  = d[`FSW_SR1_SEC];
        r.tb   = d[`FSW_SR1_TB];
        r.bp   = d[`FSW_SR1_BP_LO +: 3];
      end
      2'h2:
      begin
        r.status_protect_upper = d[`FSW_SR2_STATUS_PROTECT_UPPER];
        r.qe   = d[`FSW_SR2_QE];
        r.cmp  = d[`FSW_SR2_CMP];
      end
      2'h3:
      begin
        r.pin_role_select = d[`FSW_SR3_PIN_ROLE_SELECT];
        r.drv  = d[`FSW_SR3_DRV_LO +: 2];
        r.high_frequency_select  = d[`FSW_SR3_HFM];
        r.protect_scheme_select  = d[`FSW_SR3_WPS];
      end
      default:
      begin
        r = c;
      end
    endcase
    return r;
  endfunction

  // ----------------------------------------------------------------
  // status bytes and protection map
  // ----------------------------------------------------------------
  logic [7:0]  sr1;
  logic [7:0]  sr2;
  logic [7:0]  sr3;
  logic [23:0] addr;
  logic [24:0] span;
  logic        all_cov;
  logic        addr_cov;
  logic        addr_prot;
  logic        any_prot;
  logic        busy;

  assign busy = (st_r.op != FSW_IDLE);

  always_comb
  begin
    sr1 = 8'h00;
    sr2 = 8'h00;
    sr3 = 8'h00;
    sr1[`FSW_SR1_BUSY]      = busy;
    sr1[`FSW_SR1_WEL]       = st_r.write_enable_latch;
    sr1[`FSW_SR1_BP_LO +: 3] = st_r.vol.bp;
    sr1[`FSW_SR1_TB]        = st_r.vol.tb;
    sr1[`FSW_SR1_SEC]       = st_r.vol.sec;
    sr1[`FSW_SR1_STATUS_PROTECT_LOWER]      = st_r.vol.status_protect_lower;
    sr2[`FSW_SR2_STATUS_PROTECT_UPPER]      = st_r.vol.status_protect_upper;
    sr2[`FSW_SR2_QE]        = st_r.vol.qe;
    sr2[`FSW_SR2_LB_LO +: 3] = st_r.lb;
    sr2[`FSW_SR2_CMP]       = st_r.vol.cmp;
    sr3[`FSW_SR3_PIN_ROLE_SELECT]      = st_r.vol.pin_role_select;
    sr3[`FSW_SR3_DRV_LO +: 2] = st_r.vol.drv;
    sr3[`FSW_SR3_HFM]       = st_r.vol.high_frequency_select;
    sr3[`FSW_SR3_WPS]       = st_r.vol.protect_scheme_select;
  end

  // range doubles per step; top code with blocks covers the whole array
  always_comb
  begin
    addr     = {st_r.d1, st_r.d2, st_r.d3};
    span     = st_r.vol.sec ? (25'h1 << `FSW_SECTOR_SHIFT) : (25'h1 << `FSW_BLOCK_SHIFT);
    span     = span << (st_r.vol.bp - 3'h1);
    all_cov  = (st_r.vol.bp == 3'h7) && !st_r.vol.sec;
    if (st_r.vol.bp == 3'h0)
    begin
      addr_cov = 1'b0;
    end
    else if (all_cov)
    begin
      addr_cov = 1'b1;
    end
    else if (st_r.vol.tb)
    begin
      addr_cov = ({1'b0, addr} < span);
    end
    else
    begin
      addr_cov = ({1'b0, addr} >= (`FSW_ARRAY_BYTES - span));
    end
    addr_prot = st_r.vol.protect_scheme_select | (addr_cov ^ st_r.vol.cmp);
    any_prot  = st_r.vol.protect_scheme_select | (st_r.vol.cmp ? !all_cov : (st_r.vol.bp != 3'h0));
  end

  // ----------------------------------------------------------------
  // serial engine and command execution
  // ----------------------------------------------------------------
  logic       sclk_rise;
  logic       sclk_fall;
  logic       cs_rise;
  logic       cs_fall;
  logic       hw_reset;
  logic       sr_ok;
  logic       is_read;
  logic [7:0] rd_byte;
  logic [7:0] in_byte;
  logic [7:0] ecmd;

  always_comb
  begin
    st_nxt    = st_r;
    st_nxt.reject = 1'b0;
    st_nxt.sclk_q = pin.sclk;
    st_nxt.cs_q   = pin.cs_n;
    sclk_rise = pin.sclk && !st_r.sclk_q;
    sclk_fall = !pin.sclk && st_r.sclk_q;
    cs_rise   = pin.cs_n && !st_r.cs_q;
    cs_fall   = !pin.cs_n && st_r.cs_q;
    hw_reset  = st_r.vol.pin_role_select && !st_r.vol.qe && !pin.hr_n;
    st_nxt.hold_act = !st_r.vol.pin_role_select && !st_r.vol.qe && !pin.hr_n;
    in_byte   = {st_r.sh_in[6:0], pin.mosi};
    ecmd      = (st_r.nbytes == 3'h0) ? in_byte : st_r.cmd;
    is_read   = (ecmd == `FSW_OP_RDSR1) || (ecmd == `FSW_OP_RDSR2)
              || (ecmd == `FSW_OP_RDSR3);
    case (ecmd)
      `FSW_OP_RDSR2: rd_byte = sr2;
      `FSW_OP_RDSR3: rd_byte = sr3;
      default:       rd_byte = sr1;
    endcase
    // status protect decode
    case ({st_r.vol.status_protect_upper, st_r.vol.status_protect_lower})
      2'b00:   sr_ok = 1'b1;
      2'b01:   sr_ok = pin.wp_n || st_r.vol.qe;
      default: sr_ok = 1'b0;
    endcase

    // busy countdown
    if (busy)
    begin
      if (st_r.busy_cnt <= 24'h1)
      begin
        st_nxt.op       = FSW_IDLE;
        st_nxt.busy_cnt = 24'h0;
      end
      else
      begin
        st_nxt.busy_cnt = st_r.busy_cnt - 24'h1;
      end
    end

    if (cs_fall || pin.cs_n)
    begin
      st_nxt.bitcnt  = 3'h0;
      st_nxt.nbytes  = 3'h0;
      st_nxt.miso_oe = pin.cs_n ? 1'b0 : st_r.miso_oe;
    end
    if (!pin.cs_n && !st_r.hold_act && sclk_rise)
    begin
      st_nxt.sh_in  = in_byte;
      st_nxt.bitcnt = st_r.bitcnt + 3'h1;
      if (st_r.bitcnt == 3'h7)
      begin
        case (st_r.nbytes)
          3'h0:    st_nxt.cmd = in_byte;
          3'h1:    st_nxt.d1  = in_byte;
          3'h2:    st_nxt.d2  = in_byte;
          3'h3:    st_nxt.d3  = in_byte;
          default: st_nxt.d3  = st_r.d3;
        endcase
        if (st_r.nbytes != 3'h7)
        begin
          st_nxt.nbytes = st_r.nbytes + 3'h1;
        end
      end
    end
    // output shifts on falling edges; status refreshed each byte
    if (!pin.cs_n && !st_r.hold_act && sclk_fall && st_r.nbytes != 3'h0 && is_read)
    begin
      st_nxt.miso_oe = 1'b1;
      if (st_r.bitcnt == 3'h0)
      begin
        st_nxt.miso   = rd_byte[7];
        st_nxt.sh_out = {rd_byte[6:0], 1'b0};
      end
      else
      begin
        st_nxt.miso   = st_r.sh_out[7];
        st_nxt.sh_out = {st_r.sh_out[6:0], 1'b0};
      end
    end

    // commands act at chip-select release on a byte boundary
    if (cs_rise && st_r.bitcnt == 3'h0 && st_r.nbytes != 3'h0 && !busy)
    begin
      st_nxt.rst_armed = 1'b0;
      case (st_r.cmd)
        `FSW_OP_WREN:  st_nxt.write_enable_latch = 1'b1;
        `FSW_OP_VWREN: st_nxt.volwe = 1'b1;
        `FSW_OP_WRDI:
        begin
          st_nxt.write_enable_latch   = 1'b0;
          st_nxt.volwe = 1'b0;
        end
        `FSW_OP_WRSR1, `FSW_OP_WRSR2, `FSW_OP_WRSR3:
        begin
          if (st_r.nbytes >= 3'h2 && (st_r.write_enable_latch || st_r.volwe))
          begin
            st_nxt.write_enable_latch   = 1'b0;
            st_nxt.volwe = 1'b0;
            if (sr_ok)
            begin
              if (st_r.cmd == `FSW_OP_WRSR1)
              begin
                st_nxt.vol = cfg_write(st_r.vol, 2'h1, st_r.d1);
                if (st_r.nbytes >= 3'h3)
                begin
                  st_nxt.vol = cfg_write(cfg_write(st_r.vol, 2'h1, st_r.d1), 2'h2, st_r.d2);
                end
              end
              else
              begin
                st_nxt.vol = cfg_write(st_r.vol, (st_r.cmd == `FSW_OP_WRSR2) ? 2'h2 : 2'h3,
                                       st_r.d1);
              end
              if (st_r.write_enable_latch)
              begin
                st_nxt.nv       = st_nxt.vol;
                st_nxt.op       = FSW_WRSR;
                st_nxt.busy_cnt = 24'(WRSR_CYCLES);
                if (st_r.cmd == `FSW_OP_WRSR2)
                begin
                  st_nxt.lb = st_r.lb | st_r.d1[`FSW_SR2_LB_LO +: 3];
                end
                else if (st_r.cmd == `FSW_OP_WRSR1 && st_r.nbytes >= 3'h3)
                begin
                  st_nxt.lb = st_r.lb | st_r.d2[`FSW_SR2_LB_LO +: 3];
                end
              end
            end
          end
        end
        `FSW_OP_PP, `FSW_OP_SE, `FSW_OP_BE, `FSW_OP_CE1, `FSW_OP_CE2:
        begin
          if (st_r.write_enable_latch && ((st_r.cmd == `FSW_OP_PP && st_r.nbytes >= 3'h5)
              || ((st_r.cmd == `FSW_OP_SE || st_r.cmd == `FSW_OP_BE) && st_r.nbytes == 3'h4)
              || ((st_r.cmd == `FSW_OP_CE1 || st_r.cmd == `FSW_OP_CE2)
                  && st_r.nbytes == 3'h1)))
          begin
            st_nxt.write_enable_latch = 1'b0;
            if ((st_r.nbytes == 3'h1) ? any_prot : addr_prot)
            begin
              st_nxt.reject = 1'b1;
            end
            else if (st_r.cmd == `FSW_OP_PP)
            begin
              st_nxt.op       = FSW_PROG;
              st_nxt.busy_cnt = 24'(PROG_CYCLES);
            end
            else
            begin
              st_nxt.op       = FSW_ERASE;
              st_nxt.busy_cnt = 24'(ERASE_CYCLES);
            end
          end
        end
        `FSW_OP_RSTEN: st_nxt.rst_armed = 1'b1;
        `FSW_OP_RST:
        begin
          if (st_r.rst_armed)
          begin
            st_nxt.nv    = cfg_unlock(st_r.nv);
            st_nxt.vol   = cfg_unlock(st_r.nv);
            st_nxt.write_enable_latch   = 1'b0;
            st_nxt.volwe = 1'b0;
          end
        end
        default: st_nxt.rst_armed = 1'b0;
      endcase
    end

    // pin reset aborts everything and reloads like a soft reset
    if (hw_reset)
    begin
      st_nxt.nv       = cfg_unlock(st_r.nv);
      st_nxt.vol      = cfg_unlock(st_r.nv);
      st_nxt.write_enable_latch      = 1'b0;
      st_nxt.volwe    = 1'b0;
      st_nxt.rst_armed = 1'b0;
      st_nxt.op       = FSW_IDLE;
      st_nxt.busy_cnt = 24'h0;
      st_nxt.bitcnt   = 3'h0;
      st_nxt.nbytes   = 3'h0;
      st_nxt.miso_oe  = 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (SRST)
    begin
      st_r        <= '0;
      st_r.sclk_q <= 1'b0;
      st_r.cs_q   <= 1'b1;
      st_r.op     <= FSW_IDLE;
      st_r.nv     <= cfg_reset();
      st_r.vol    <= cfg_reset();
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign MISO           = st_r.miso;
  assign MISO_OE        = st_r.miso_oe;
  assign DRIVE_STRENGTH = st_r.vol.drv;
  assign HIGH_FREQ_MODE = st_r.vol.high_frequency_select;
  assign QUAD_MODE      = st_r.vol.qe;
  assign HOLD_ACTIVE    = st_r.hold_act;
  assign BUSY           = (st_r.op != FSW_IDLE);
  assign ARRAY_REJECT   = st_r.reject;

endmodule
